// ==== rtl/flic_top.sv ====
// four-level, sixteen-source interrupt controller with vector strobe
// assumes peripheral flags arrive on core_clk; external inputs are async pins
`timescale 1ns/1ps
// How it works
// - sixteen sources, each on one of four levels
// - request needs own enable and global enable
// - software writes flags like hardware does
// - same level: lower source number wins
// - vectors eight bytes apart, last skips slot
// - each external input level or edge typed
// - edge flags cleared on vector, level follows pin
// - timer 0/1 flags cleared on vector
// - uart0 request is rx or tx, software clears
// - timer2 overflow or external, never auto cleared
// - spi done flag requests, stays set
// - adc done flag requests, stays set
// - pca overflow or module flags, software clears
// - brownout or watchdog flags request, stay set
// - uart1 request is rx or tx, software clears
// - keypad match flag requests, stays set
// - two-wire state flag requests, stays set
// - timer3 overflow or external, never auto cleared
// - external flags at fixed control register bits
// - per-source high and low priority bits
// - 11 highest, 10, 01, 00 lowest
// - lower level never preempts, higher wins
// - block on active level, mid-instruction, reti/config
// - global enable low disables everything
module flic_top
    import flic_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [EXT_COUNT-1:0] extIrqInput,
    input wire logic timerCtrlWrite,
    input wire logic [7:0] timerCtrlData,
    input wire logic extCtrlWrite,
    input wire logic [7:0] extCtrlData,
    input wire logic globalIrqEnable,
    input wire logic [SRC_COUNT-1:0] irqEnable,
    input wire logic [SRC_COUNT-1:0] prioHigh,
    input wire logic [SRC_COUNT-1:0] prioLow,
    input wire logic timer0OverflowFlag,
    input wire logic timer1OverflowFlag,
    input wire logic timer2OverflowFlag,
    input wire logic timer2ExternalFlag,
    input wire logic timer3OverflowFlag,
    input wire logic timer3ExternalFlag,
    input wire logic uart0RxFlag,
    input wire logic uart0TxFlag,
    input wire logic uart1RxFlag,
    input wire logic uart1TxFlag,
    input wire logic spiDoneFlag,
    input wire logic adcDoneFlag,
    input wire logic pcaOverflowFlag,
    input wire logic [5:0] pcaModuleFlags,
    input wire logic brownout0Flag,
    input wire logic brownout1Flag,
    input wire logic watchdogOverflowFlag,
    input wire logic keypadMatchFlag,
    input wire logic twoWireStateFlag,
    input wire logic instrLastCycle,
    input wire logic noVectorInstr,
    input wire logic vectorAck,
    input wire logic irqReturn,
    output logic irqRequest_r,
    output logic [15:0] irqVector_r,
    output logic [SRC_IDX_W-1:0] irqSource_r,
    output logic [LVL_W-1:0] irqLevel_r,
    output logic [LVL_COUNT-1:0] activeLevels_r,
    output logic timer0FlagClear_r,
    output logic timer1FlagClear_r,
    output logic [7:0] timerCtrlImage_r,
    output logic [7:0] extCtrlImage_r
);

    // ************************************************************
    // helper functions
    // ************************************************************
    function automatic logic [15:0] vecAddr(input logic [SRC_IDX_W-1:0] idx);
        logic [4:0] slot;
        slot = (idx == SRC_TIMER3) ? VEC_LAST_SLOT : {1'b0, idx};
        return VEC_BASE + 16'({slot, 3'b000});
    endfunction

    function automatic logic [LVL_W:0] topActive(input logic [LVL_COUNT-1:0] act);
        logic [LVL_W:0] top;
        top = '0;
        for (int i = 0; i < LVL_COUNT; i++)
        begin
            if (act[i])
            begin
                top = {1'b1, LVL_W'(i)};
            end
        end
        return top;
    endfunction

    function automatic int flagBit(input int n);
        return (n == 0) ? TCR_EXT0_FLAG_BIT : (n == 1) ? TCR_EXT1_FLAG_BIT :
               (n == 2) ? XCR_EXT2_FLAG_BIT : XCR_EXT3_FLAG_BIT;
    endfunction

    function automatic int typeBit(input int n);
        return (n == 0) ? TCR_EXT0_TYPE_BIT : (n == 1) ? TCR_EXT1_TYPE_BIT :
               (n == 2) ? XCR_EXT2_TYPE_BIT : XCR_EXT3_TYPE_BIT;
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    logic [EXT_COUNT-1:0] extSync1_r;
    logic [EXT_COUNT-1:0] extSync2_r;
    logic [EXT_COUNT-1:0] extPrev_r;
    logic [EXT_COUNT-1:0] extFlag;
    logic [EXT_COUNT-1:0] extType;
    logic [EXT_COUNT-1:0] extEdgeSet;
    logic [SRC_COUNT-1:0] rawReq;
    logic [SRC_COUNT-1:0] sampledReq_r;
    logic winValid;
    logic [SRC_IDX_W-1:0] winIdx;
    logic [LVL_W-1:0] winLevel;
    logic [LVL_W:0] topLvl;
    logic levelOk;
    logic blocked;
    logic ackTake;

    assign ackTake = vectorAck && irqRequest_r;
    assign topLvl = topActive(activeLevels_r);
    assign levelOk = !topLvl[LVL_W] || (winLevel > topLvl[LVL_W-1:0]);
    assign blocked = !instrLastCycle || noVectorInstr || !levelOk;

    // ************************************************************
    // external input synchronisers
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            extSync1_r <= SYNC_RST;
            extSync2_r <= SYNC_RST;
            extPrev_r <= SYNC_RST;
        end
        else if (clkEn)
        begin
            extSync1_r <= extIrqInput;
            extSync2_r <= extSync1_r;
            extPrev_r <= extSync2_r;
        end
    end

    // ************************************************************
    // external request flags and trigger types
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < EXT_COUNT; g++)
        begin : g_ext
            logic flag_r;
            logic type_r;
            logic swWe;
            logic swFlag;
            logic swType;
            logic vecClr;
            assign swWe = (g < 2) ? timerCtrlWrite : extCtrlWrite;
            assign swFlag = (g < 2) ? timerCtrlData[flagBit(g)] : extCtrlData[flagBit(g)];
            assign swType = (g < 2) ? timerCtrlData[typeBit(g)] : extCtrlData[typeBit(g)];
            assign vecClr = ackTake && (irqSource_r == EXT_SRC_IDX[4*g +: 4]) && type_r;
            assign extEdgeSet[g] = type_r && extPrev_r[g] && !extSync2_r[g];
            assign extFlag[g] = flag_r;
            assign extType[g] = type_r;

            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    type_r <= EXT_TYPE_RST[g];
                end
                else if (clkEn && swWe)
                begin
                    type_r <= swType;
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    flag_r <= EXT_FLAG_RST[g];
                end
                else if (clkEn)
                begin
                    if (!type_r)
                    begin
                        flag_r <= swWe ? swFlag : !extSync2_r[g];
                    end
                    else if (extEdgeSet[g])
                    begin
                        flag_r <= 1'b1;
                    end
                    else if (vecClr)
                    begin
                        flag_r <= 1'b0;
                    end
                    else if (swWe)
                    begin
                        flag_r <= swFlag;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // readback images of the control registers
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            timerCtrlImage_r <= 8'h00;
            extCtrlImage_r <= 8'h00;
        end
        else if (clkEn)
        begin
            timerCtrlImage_r <= 8'h00;
            extCtrlImage_r <= 8'h00;
            timerCtrlImage_r[TCR_EXT0_FLAG_BIT] <= extFlag[0];
            timerCtrlImage_r[TCR_EXT1_FLAG_BIT] <= extFlag[1];
            timerCtrlImage_r[TCR_EXT0_TYPE_BIT] <= extType[0];
            timerCtrlImage_r[TCR_EXT1_TYPE_BIT] <= extType[1];
            extCtrlImage_r[XCR_EXT2_FLAG_BIT] <= extFlag[2];
            extCtrlImage_r[XCR_EXT3_FLAG_BIT] <= extFlag[3];
            extCtrlImage_r[XCR_EXT2_TYPE_BIT] <= extType[2];
            extCtrlImage_r[XCR_EXT3_TYPE_BIT] <= extType[3];
        end
    end

    // ************************************************************
    // source requests, sampled then polled
    // ************************************************************
    always_comb
    begin
        rawReq = '0;
        rawReq[SRC_EXT0] = extFlag[0];
        rawReq[SRC_TIMER0] = timer0OverflowFlag;
        rawReq[SRC_EXT1] = extFlag[1];
        rawReq[SRC_TIMER1] = timer1OverflowFlag;
        rawReq[SRC_UART0] = uart0RxFlag || uart0TxFlag;
        rawReq[SRC_TIMER2] = timer2OverflowFlag || timer2ExternalFlag;
        rawReq[SRC_EXT2] = extFlag[2];
        rawReq[SRC_EXT3] = extFlag[3];
        rawReq[SRC_SPI] = spiDoneFlag;
        rawReq[SRC_ADC] = adcDoneFlag;
        rawReq[SRC_PCA] = pcaOverflowFlag || (|pcaModuleFlags);
        rawReq[SRC_SYSFLAG] = brownout0Flag || brownout1Flag || watchdogOverflowFlag;
        rawReq[SRC_UART1] = uart1RxFlag || uart1TxFlag;
        rawReq[SRC_KEYPAD] = keypadMatchFlag;
        rawReq[SRC_TWOWIRE] = twoWireStateFlag;
        rawReq[SRC_TIMER3] = timer3OverflowFlag || timer3ExternalFlag;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sampledReq_r <= '0;
        end
        else if (clkEn)
        begin
            sampledReq_r <= rawReq & irqEnable & {SRC_COUNT{globalIrqEnable}};
        end
    end

    flic_arbiter #(
        .N(SRC_COUNT)
    ) u_arbiter (
        .pend(sampledReq_r),
        .prioHigh(prioHigh),
        .prioLow(prioLow),
        .winValid(winValid),
        .winIdx(winIdx),
        .winLevel(winLevel)
    );

    // ************************************************************
    // vector request to the cpu
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irqRequest_r <= 1'b0;
            irqVector_r <= VECTOR_RST;
            irqSource_r <= '0;
            irqLevel_r <= '0;
        end
        else if (clkEn)
        begin
            if (ackTake)
            begin
                irqRequest_r <= 1'b0;
            end
            else
            begin
                irqRequest_r <= winValid && !blocked;
                irqVector_r <= vecAddr(winIdx);
                irqSource_r <= winIdx;
                irqLevel_r <= winLevel;
            end
        end
    end

    // ************************************************************
    // active levels and automatic clears
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            activeLevels_r <= ACTIVE_RST;
        end
        else if (clkEn)
        begin
            if (ackTake)
            begin
                activeLevels_r[irqLevel_r] <= 1'b1;
            end
            else if (irqReturn && topLvl[LVL_W])
            begin
                activeLevels_r[topLvl[LVL_W-1:0]] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            timer0FlagClear_r <= 1'b0;
            timer1FlagClear_r <= 1'b0;
        end
        else if (clkEn)
        begin
            timer0FlagClear_r <= ackTake && (irqSource_r == SRC_TIMER0);
            timer1FlagClear_r <= ackTake && (irqSource_r == SRC_TIMER1);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [SRC_COUNT-1:0] sameLvl;
    logic [SRC_COUNT-1:0] higherLvl;
    logic [SRC_COUNT-1:0] lowerIdx;
    always_comb
    begin
        sameLvl = '0;
        higherLvl = '0;
        lowerIdx = '0;
        for (int i = 0; i < SRC_COUNT; i++)
        begin
            sameLvl[i] = ({prioHigh[i], prioLow[i]} == winLevel);
            higherLvl[i] = ({prioHigh[i], prioLow[i]} > winLevel);
            lowerIdx[i] = (i < int'(winIdx));
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !clkEn);

    sequence s_take;
        ackTake;
    endsequence

    sequence s_level_marked;
        activeLevels_r[$past(irqLevel_r)] && !irqRequest_r;
    endsequence

    a_vector_address: assert property (irqRequest_r |-> irqVector_r == vecAddr(irqSource_r))
        else $error("vector address does not match source");
    a_global_gate: assert property ((sampledReq_r != '0) |-> $past(globalIrqEnable))
        else $error("request sampled while global enable low");
    a_source_gate: assert property ((sampledReq_r & ~$past(irqEnable)) == '0)
        else $error("request sampled without its own enable");
    a_poll_order: assert property (winValid |-> (sampledReq_r & sameLvl & lowerIdx) == '0)
        else $error("lower numbered source of same level skipped");
    a_level_wins: assert property (winValid |-> (sampledReq_r & higherLvl) == '0)
        else $error("higher level request skipped");
    a_block_instr: assert property ((!instrLastCycle || noVectorInstr) && !irqRequest_r |=> !irqRequest_r)
        else $error("vector raised in blocked cycle");
    a_active_block: assert property (irqRequest_r && topLvl[LVL_W] |-> irqLevel_r > topLvl[LVL_W-1:0])
        else $error("request not above active level");
    a_ack_marks: assert property (s_take |=> s_level_marked)
        else $error("acknowledge did not mark level or drop request");
    a_timer_clear: assert property (s_take ##0 (irqSource_r == SRC_TIMER0) |=> timer0FlagClear_r ##1 !timer0FlagClear_r)
        else $error("timer 0 flag clear pulse wrong");
    a_edge_clear: assert property (s_take ##0 (irqSource_r == SRC_EXT0) && extType[0] && !extEdgeSet[0] |=> !extFlag[0])
        else $error("edge flag not cleared on vector");
    a_level_follow: assert property (!extType[0] && !$past(timerCtrlWrite) |-> extFlag[0] == !$past(extSync2_r[0]))
        else $error("level flag does not follow input");
    a_level_code: assert property ($rose(irqRequest_r) |->
        irqLevel_r == $past({prioHigh[winIdx], prioLow[winIdx]}))
        else $error("level does not match priority bits");

endmodule

// ==== rtl/flic_pkg.sv ====
// constants shared by the four-level interrupt controller files
// assumes one 20 MHz system clock and a synchronous active-high reset
package flic_pkg;

    // ************************************************************
    // sources and levels
    // ************************************************************
    localparam int SRC_COUNT = 16;
    localparam int SRC_IDX_W = 4;
    localparam int LVL_COUNT = 4;
    localparam int LVL_W = 2;
    localparam int EXT_COUNT = 4;

    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TIMER0 = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TIMER1 = 4'h3;
    localparam logic [3:0] SRC_UART0 = 4'h4;
    localparam logic [3:0] SRC_TIMER2 = 4'h5;
    localparam logic [3:0] SRC_EXT2 = 4'h6;
    localparam logic [3:0] SRC_EXT3 = 4'h7;
    localparam logic [3:0] SRC_SPI = 4'h8;
    localparam logic [3:0] SRC_ADC = 4'h9;
    localparam logic [3:0] SRC_PCA = 4'ha;
    localparam logic [3:0] SRC_SYSFLAG = 4'hb;
    localparam logic [3:0] SRC_UART1 = 4'hc;
    localparam logic [3:0] SRC_KEYPAD = 4'hd;
    localparam logic [3:0] SRC_TWOWIRE = 4'he;
    localparam logic [3:0] SRC_TIMER3 = 4'hf;
    localparam logic [15:0] EXT_SRC_IDX = {SRC_EXT3, SRC_EXT2, SRC_EXT1, SRC_EXT0};

    // ************************************************************
    // vector table
    // ************************************************************
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [4:0] VEC_LAST_SLOT = 5'h10;

    // ************************************************************
    // control register bit positions
    // ************************************************************
    localparam int TCR_EXT0_TYPE_BIT = 0;
    localparam int TCR_EXT0_FLAG_BIT = 1;
    localparam int TCR_EXT1_TYPE_BIT = 2;
    localparam int TCR_EXT1_FLAG_BIT = 3;
    localparam int XCR_EXT2_TYPE_BIT = 0;
    localparam int XCR_EXT2_FLAG_BIT = 1;
    localparam int XCR_EXT3_TYPE_BIT = 4;
    localparam int XCR_EXT3_FLAG_BIT = 5;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] EXT_FLAG_RST = 4'h0;
    localparam logic [3:0] EXT_TYPE_RST = 4'h0;
    localparam logic [3:0] ACTIVE_RST = 4'h0;
    localparam logic [3:0] SYNC_RST = 4'hf;
    localparam logic [15:0] VECTOR_RST = 16'h0000;

endpackage

// ==== rtl/flic_arbiter.sv ====
// fixed-order, four-level winner select over the sampled requests
// assumes registered requests and level bits on the same clock
`timescale 1ns/1ps
module flic_arbiter
    import flic_pkg::*;
#(
    parameter int N = SRC_COUNT
)
(
    input wire logic [N-1:0] pend,
    input wire logic [N-1:0] prioHigh,
    input wire logic [N-1:0] prioLow,
    output logic winValid,
    output logic [SRC_IDX_W-1:0] winIdx,
    output logic [LVL_W-1:0] winLevel
);

    // ************************************************************
    // level first, then lowest source number
    // ************************************************************
    always_comb
    begin
        winValid = 1'b0;
        winIdx = '0;
        winLevel = '0;
        for (int lv = LVL_COUNT - 1; lv >= 0; lv--)
        begin
            for (int i = N - 1; i >= 0; i--)
            begin
                if (!winValid && pend[i] && ({prioHigh[i], prioLow[i]} == LVL_W'(lv)))
                begin
                    winIdx = SRC_IDX_W'(i);
                    winLevel = LVL_W'(lv);
                end
            end
            if (!winValid && (winIdx != '0 || (pend[0] && {prioHigh[0], prioLow[0]} == LVL_W'(lv))))
            begin
                winValid = 1'b1;
            end
            else if (!winValid)
            begin
                winIdx = '0;
            end
        end
    end

endmodule

// ==== test/flic_cpu_model.sv ====
// cpu stand-in: paces instruction ends and acks vector requests
// assumes the bench pulses irqReturn itself
`timescale 1ns/1ps
module flic_cpu_model
(
    input wire logic core_clk,
    input wire logic irqRequest_r,
    output logic vectorAck,
    output logic instrLastCycle,
    output logic noVectorInstr
);
    int mSeed = 76458;
    logic [1:0] waitCnt = 2'h0;
    logic [1:0] ackWait = 2'h0;
    initial
    begin
        vectorAck = 1'b0;
        instrLastCycle = 1'b1;
        noVectorInstr = 1'b0;
    end
    // ************************************************************
    // random pacing, prompt or slow ack
    // ************************************************************
    always @(negedge core_clk)
    begin
        instrLastCycle <= ($random(mSeed) & 3) != 0;
        noVectorInstr <= ($random(mSeed) & 7) == 0;
        waitCnt <= irqRequest_r ? waitCnt + 2'h1 : 2'h0;
        vectorAck <= irqRequest_r && !vectorAck && waitCnt >= ackWait;
        if (vectorAck)
            ackWait <= 2'($random(mSeed));
    end
endmodule

// ==== test/flic_top_tb.sv ====
// self-checking bench for the four-level interrupt controller
// assumes flic_cpu_model answers vector requests
`timescale 1ns/1ps
module flic_top_tb
    import flic_pkg::*;
;
    logic core_clk = 0, rst = 1, glb = 0, tcW = 0, xcW = 0, ret = 0;
    logic [7:0] tcD = 8'h00, xcD = 8'h00, tImg, xImg;
    logic [3:0] pins = 4'hf, src, act;
    logic [15:0] en = 16'h0, pH = 16'h0, pL = 16'h0, f = 16'h0, vec;
    logic [2:0] pick = 3'h0;
    logic [1:0] lvl;
    logic ack, ilc, nvi, req, t0c, t1c;
    int mismatches = 0, checked = 0, seed = 76458, served = 0, cyc = 0;
    logic [21:0] expQ[$];

    initial
        forever #25 core_clk = ~core_clk;

    flic_top DUT (.core_clk(core_clk), .rst(rst), .clkEn(1'b1), .extIrqInput(pins),
        .timerCtrlWrite(tcW), .timerCtrlData(tcD), .extCtrlWrite(xcW), .extCtrlData(xcD),
        .globalIrqEnable(glb), .irqEnable(en), .prioHigh(pH), .prioLow(pL),
        .timer0OverflowFlag(f[1]), .timer1OverflowFlag(f[3]),
        .timer2OverflowFlag(f[5] & ~pick[0]), .timer2ExternalFlag(f[5] & pick[0]),
        .timer3OverflowFlag(f[15] & ~pick[0]), .timer3ExternalFlag(f[15] & pick[0]),
        .uart0RxFlag(f[4] & ~pick[0]), .uart0TxFlag(f[4] & pick[0]),
        .uart1RxFlag(f[12] & ~pick[0]), .uart1TxFlag(f[12] & pick[0]),
        .spiDoneFlag(f[8]), .adcDoneFlag(f[9]), .pcaOverflowFlag(f[10] & (pick > 3'h5)),
        .pcaModuleFlags({6{f[10]}} & (6'h01 << pick)), .brownout0Flag(f[11] & (pick[1:0] == 2'h0)),
        .brownout1Flag(f[11] & (pick[1:0] == 2'h1)), .watchdogOverflowFlag(f[11] & pick[1]),
        .keypadMatchFlag(f[13]), .twoWireStateFlag(f[14]), .instrLastCycle(ilc),
        .noVectorInstr(nvi), .vectorAck(ack), .irqReturn(ret), .irqRequest_r(req),
        .irqVector_r(vec), .irqSource_r(src), .irqLevel_r(lvl), .activeLevels_r(act),
        .timer0FlagClear_r(t0c), .timer1FlagClear_r(t1c), .timerCtrlImage_r(tImg),
        .extCtrlImage_r(xImg));

    flic_cpu_model cpu (.core_clk(core_clk), .irqRequest_r(req), .vectorAck(ack),
        .instrLastCycle(ilc), .noVectorInstr(nvi));

    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            complete_run();
        end
        if (!rst && ack && req)
        begin
            check({src, lvl, vec}, expQ.size() ? expQ.pop_front() : 22'h3fffff);
            served++;
        end
    end

    // ************************************************************
    // stimulus tasks
    // ************************************************************
    task automatic wr(input logic [7:0] t, input logic [7:0] x);
        tcD = t;
        xcD = x;
        tcW = 1;
        xcW = 1;
        @(negedge core_clk);
        tcW = 0;
        xcW = 0;
    endtask

    task automatic serve(input int s, input logic hw, input logic [15:0] img);
        int n;
        logic [1:0] l;
        n = served;
        l = {pH[s], pL[s]};
        expQ.push_back({4'(s), l, (s == 15) ? 16'h0083 : 16'h0003 + 16'(s * 8)});
        for (int i = 0; i < 300 && served == n; i++)
            @(negedge core_clk);
        check(22'(served - n), 22'h1);
        check({t0c, t1c}, {s == 1, s == 3});
        @(negedge core_clk);
        check({tImg, xImg}, img);
        if (hw)
        begin
            f[s] = 1'b0;
            pins = 4'hf;
        end
        repeat (6) @(negedge core_clk);
        check(act, 4'h1 << l);
        // hold other pending sources until the next call notes them
        glb = 0;
        ret = 1;
        @(negedge core_clk);
        ret = 0;
        repeat (3) @(negedge core_clk);
        glb = 1;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        int w;
        repeat (12) @(negedge core_clk);
        rst = 0;
        glb = 1;
        wr(8'h05, 8'h11);
        for (int s = 0; s < 16; s++)
        begin
            {pH[s], pL[s]} = 2'($random(seed));
            en = 16'h0001 << s;
            pick = 3'($random(seed));
            if (s == 0 || s == 2 || s == 6 || s == 7)
                wr(s == 0 ? 8'h07 : s == 2 ? 8'h0d : 8'h05, s == 6 ? 8'h13 : s == 7 ? 8'h31 : 8'h11);
            else
                f[s] = 1'b1;
            serve(s, !(s == 0 || s == 2 || s == 6 || s == 7), 16'h0511);
        end
        $display("test vectors done");
        en = 16'hff3a;
        pH = 16'($random(seed));
        pL = 16'($random(seed));
        f = 16'hff3a;
        repeat (12)
        begin
            w = -1;
            for (int i = 0; i < 16; i++)
                if (f[i] && (w < 0 || {pH[i], pL[i]} > {pH[w], pL[w]}))
                    w = i;
            serve(w, 1, 16'h0511);
        end
        $display("test priority done");
        pH = 16'h0200;
        pL = 16'h0200;
        en = 16'h0300;
        f = 16'h0100;
        expQ.push_back({4'h8, 2'h0, 16'h0043});
        for (int i = 0; i < 300 && expQ.size() != 0; i++)
            @(negedge core_clk);
        f = 16'h0200;
        expQ.push_back({4'h9, 2'h3, 16'h004b});
        for (int i = 0; i < 300 && expQ.size() != 0; i++)
            @(negedge core_clk);
        check(22'(expQ.size()), 22'h0);
        check(act, 4'h9);
        f = 16'h0000;
        repeat (2)
        begin
            ret = 1;
            @(negedge core_clk);
            ret = 0;
            @(negedge core_clk);
        end
        repeat (4) @(negedge core_clk);
        check(act, 4'h0);
        $display("test preempt done");
        glb = 0;
        en = 16'hffff;
        f = 16'hff3a;
        repeat (20) @(negedge core_clk);
        check(22'(req), 22'h0);
        glb = 1;
        en = 16'h0000;
        repeat (20) @(negedge core_clk);
        check(22'(req), 22'h0);
        f = 16'h0000;
        wr(8'h00, 8'h00);
        en = 16'h0001;
        pins = 4'he;
        serve(0, 1, 16'h0200);
        wr(8'h05, 8'h11);
        en = 16'h0004;
        pins = 4'hd;
        serve(2, 1, 16'h0511);
        $display("test gating done");
        complete_run();
    end
endmodule
